// >>> rtl/asrp_ctrl.sv
`timescale 1ns/1ps
module asrp_ctrl
  import asrp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic ready_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic wdone_o,
  output logic select_low_n_o,
  output logic select_high_o,
  output logic strobe_n_o,
  output logic out_en_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic [DATA_W-1:0] dq_i
);

  typedef struct packed {
    asrp_state_e state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic wdone;
    logic sel_n;
    logic sel;
    logic strobe_n;
    logic oe_n;
    logic dq_oe_n;
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_sync;
  } asrp_ctrl_s;

  asrp_ctrl_s st_reg;
  asrp_ctrl_s st_next;
  logic tmr_load;
  logic [TIMER_W-1:0] tmr_val;
  logic tmr_last;

  localparam asrp_ctrl_s RST_VAL = '{state: ASRP_IDLE, addr: '0, wdata: '0, rdata: '0,
    rvalid: 1'b0, wdone: 1'b0, sel_n: 1'b1, sel: 1'b0, strobe_n: 1'b1, oe_n: 1'b1,
    dq_oe_n: 1'b1, dq_meta: '0, dq_sync: '0};

  // ----------------------------------------------------------------
  // phase timer
  // ----------------------------------------------------------------
  asrp_timer #(
    .W(TIMER_W)
  ) u_timer (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .last_o(tmr_last)
  );

  // ----------------------------------------------------------------
  // next state and pin levels
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    tmr_load = 1'b0;
    tmr_val = '0;
    st_next.rvalid = 1'b0;
    st_next.wdone = 1'b0;
    // first flop feeds only the second one
    st_next.dq_meta = dq_i;
    st_next.dq_sync = st_reg.dq_meta;
    case (st_reg.state)
      ASRP_IDLE:
      begin
        if (req_i)
        begin
          st_next.addr = addr_i;
          st_next.wdata = wdata_i;
          tmr_load = 1'b1;
          if (we_i)
          begin
            st_next.state = ASRP_WR_SETUP;
            tmr_val = TIMER_W'(SETUP_CYC);
          end
          else
          begin
            st_next.state = ASRP_RD_ACC;
            tmr_val = TIMER_W'(ACCESS_CYC);
          end
        end
      end
      ASRP_RD_ACC:
      begin
        if (tmr_last)
        begin
          st_next.state = ASRP_RD_SYNC;
          tmr_load = 1'b1;
          tmr_val = TIMER_W'(SYNC_STAGES);
        end
      end
      ASRP_RD_SYNC:
      begin
        if (tmr_last)
        begin
          st_next.state = ASRP_IDLE;
          st_next.rdata = st_reg.dq_sync;
          st_next.rvalid = 1'b1;
        end
      end
      ASRP_WR_SETUP:
      begin
        if (tmr_last)
        begin
          st_next.state = ASRP_WR_HIZ;
          tmr_load = 1'b1;
          tmr_val = TIMER_W'(HIZ_CYC);
        end
      end
      ASRP_WR_HIZ:
      begin
        if (tmr_last)
        begin
          st_next.state = ASRP_WR_DATA;
          tmr_load = 1'b1;
          tmr_val = TIMER_W'(WDATA_CYC);
        end
      end
      ASRP_WR_DATA:
      begin
        if (tmr_last)
        begin
          st_next.state = ASRP_WR_HOLD;
          tmr_load = 1'b1;
          tmr_val = TIMER_W'(HOLD_CYC);
        end
      end
      ASRP_WR_HOLD:
      begin
        if (tmr_last)
        begin
          st_next.state = ASRP_IDLE;
          st_next.wdone = 1'b1;
        end
      end
      default:
      begin
        st_next.state = ASRP_IDLE;
      end
    endcase
    // pins follow the phase being entered
    st_next.sel_n = (st_next.state == ASRP_IDLE);
    st_next.sel = (st_next.state != ASRP_IDLE);
    st_next.oe_n = !((st_next.state == ASRP_RD_ACC) || (st_next.state == ASRP_RD_SYNC));
    st_next.strobe_n = !((st_next.state == ASRP_WR_HIZ) ||
      (st_next.state == ASRP_WR_DATA));
    st_next.dq_oe_n = !((st_next.state == ASRP_WR_DATA) ||
      (st_next.state == ASRP_WR_HOLD));
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_reg <= RST_VAL;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ready_o = (st_reg.state == ASRP_IDLE);
  assign rdata_o = st_reg.rdata;
  assign rvalid_o = st_reg.rvalid;
  assign wdone_o = st_reg.wdone;
  assign select_low_n_o = st_reg.sel_n;
  assign select_high_o = st_reg.sel;
  assign strobe_n_o = st_reg.strobe_n;
  assign out_en_n_o = st_reg.oe_n;
  assign addr_o = st_reg.addr;
  assign dq_o = st_reg.wdata;
  assign dq_oe_n_o = st_reg.dq_oe_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] low_cnt;
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      low_cnt <= '0;
    end
    else if (!strobe_n_o)
    begin
      low_cnt <= low_cnt + 1'b1;
    end
    else
    begin
      low_cnt <= '0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_read_addr_stable: assert property ((!out_en_n_o && !$past(out_en_n_o)) |->
    $stable(addr_o)) else $error("address moved during read");
  a_read_ctrl_held: assert property ($fell(out_en_n_o) |-> (!out_en_n_o && strobe_n_o &&
    !select_low_n_o && select_high_o)[*3]) else $error("read controls not held");
  a_read_latency: assert property ($fell(out_en_n_o) |-> ##3 rvalid_o)
    else $error("read data not returned on time");
  a_strobe_end_sel: assert property ($rose(strobe_n_o) |-> !select_low_n_o && select_high_o)
    else $error("strobe rose while deselected");
  a_pulse_width: assert property ($rose(strobe_n_o) |-> $past(low_cnt) >= TIMER_W'(PULSE_CYC))
    else $error("write pulse too short");
  a_hiz_wait: assert property ($fell(strobe_n_o) |-> dq_oe_n_o)
    else $error("data driven before float time");
  a_no_contend: assert property (!dq_oe_n_o |-> out_en_n_o)
    else $error("data driven while memory outputs on");
  a_wr_addr_stable: assert property ((!strobe_n_o && !$past(strobe_n_o)) |-> $stable(addr_o))
    else $error("address moved during write pulse");
  a_hold_after: assert property ($rose(strobe_n_o) |-> !dq_oe_n_o && select_high_o)
    else $error("data or select dropped with strobe");

  c_read: cover property (rvalid_o);
  c_write: cover property (wdone_o);
  c_wr_then_rd: cover property (wdone_o ##[1:4] rvalid_o);

endmodule : asrp_ctrl

// >>> rtl/asrp_pkg.sv
package asrp_pkg;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int WORDS = 524288;

  // ----------------------------------------------------------------
  // timing, in ns as specified
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int READ_CYCLE_TIME_NS = 15;
  localparam int ADDRESS_ACCESS_TIME_NS = 15;
  localparam int SELECT_ACCESS_TIME_NS = 15;
  localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 7;
  localparam int ADDR_SETUP_WR_NS = 1;
  localparam int STROBE_PULSE_WIDTH_NS = 12;
  localparam int STROBE_TO_HIZ_TIME_NS = 5;
  localparam int DATA_SETUP_NS = 7;
  localparam int ADDR_HOLD_WR_NS = 2;
  localparam int DATA_HOLD_NS = 2;

  // least times round up to whole cycles, never below one
  function automatic int asrp_cyc(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : asrp_cyc

  function automatic int asrp_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : asrp_max

  // ----------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------
  localparam int ACCESS_CYC = asrp_max(asrp_max(asrp_cyc(ADDRESS_ACCESS_TIME_NS),
    asrp_cyc(SELECT_ACCESS_TIME_NS)), asrp_max(asrp_cyc(OUTPUT_ENABLE_ACCESS_TIME_NS),
    asrp_cyc(READ_CYCLE_TIME_NS)));
  localparam int SYNC_STAGES = 2;
  localparam int SETUP_CYC = asrp_cyc(ADDR_SETUP_WR_NS);
  localparam int HIZ_CYC = asrp_cyc(STROBE_TO_HIZ_TIME_NS);
  localparam int PULSE_CYC = asrp_cyc(STROBE_PULSE_WIDTH_NS);
  localparam int WDATA_CYC = asrp_max(asrp_cyc(DATA_SETUP_NS), PULSE_CYC - HIZ_CYC);
  localparam int HOLD_CYC = asrp_max(asrp_cyc(ADDR_HOLD_WR_NS), asrp_cyc(DATA_HOLD_NS));

  localparam int TIMER_W = 4;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ASRP_IDLE = 3'h0,
    ASRP_RD_ACC = 3'h1,
    ASRP_RD_SYNC = 3'h2,
    ASRP_WR_SETUP = 3'h3,
    ASRP_WR_HIZ = 3'h4,
    ASRP_WR_DATA = 3'h5,
    ASRP_WR_HOLD = 3'h6
  } asrp_state_e;

endpackage : asrp_pkg

// >>> rtl/asrp_timer.sv
`timescale 1ns/1ps
module asrp_timer
  import asrp_pkg::*;
#(
  parameter int W = TIMER_W
)(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  output logic last_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } asrp_timer_s;

  asrp_timer_s st_reg;
  asrp_timer_s st_next;

  // ----------------------------------------------------------------
  // down counter, last marks final cycle of a phase
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    if (load_i)
    begin
      st_next.cnt = load_val_i;
    end
    else if (st_reg.cnt != '0)
    begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign last_o = (st_reg.cnt <= W'(1));

endmodule : asrp_timer

// >>> sim/asrp_sram_model.sv
`timescale 1ns/1ps
module asrp_sram_model
  import asrp_pkg::*;
#(
  parameter int ACC_NS = ADDRESS_ACCESS_TIME_NS
)(
  input wire logic select_low_n_i,
  input wire logic select_high_i,
  input wire logic strobe_n_i,
  input wire logic out_en_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_ctl_i,
  input wire logic dq_ctl_oe_n_i,
  output logic [DATA_W-1:0] dq_o,
  output logic viol_o
);
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] last_v = 8'h00;
  logic sel;
  logic wr;
  logic drv;
  // ----------------------------------------------------------------
  // decode of the control pins
  // ----------------------------------------------------------------
  assign sel = !select_low_n_i && select_high_i;
  assign wr = sel && !strobe_n_i;
  assign drv = sel && !out_en_n_i && strobe_n_i;
  // new access on select or address change, data late by access time
  always @(sel or addr_i or drv) rd <= #(ACC_NS) mem[addr_i];
  // resolved bus, a released bus shows the inverse of its last level
  always @*
  begin
    if (!dq_ctl_oe_n_i) dq_o = dq_ctl_i;
    else if (drv) dq_o = rd;
    else dq_o = ~last_v;
  end
  always @(dq_ctl_oe_n_i or drv or rd or dq_ctl_i)
  begin
    if (!dq_ctl_oe_n_i) last_v = dq_ctl_i;
    else if (drv) last_v = rd;
  end
  // store when strobe or select ends the write
  always @(negedge wr) mem[addr_i] = dq_o;
  // flags for contention and address moving in a write
  initial viol_o = 1'b0;
  always @(addr_i) if (wr) viol_o = 1'b1;
  always @(drv or dq_ctl_oe_n_i) if (drv && !dq_ctl_oe_n_i) viol_o = 1'b1;
endmodule : asrp_sram_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import asrp_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_i = 1'b0;
  logic we_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic ready_o, rvalid_o, wdone_o, select_low_n_o, select_high_o;
  logic strobe_n_o, out_en_n_o, dq_oe_n_o, viol;
  logic [DATA_W-1:0] rdata_o, dq_o, dq_bus;
  logic [ADDR_W-1:0] addr_o;
  int n_fail = 0;
  int compares = 0;
  // ----------------------------------------------------------------
  // clock, controller and memory
  // ----------------------------------------------------------------
  always #10 mclk_i = ~mclk_i;
  asrp_ctrl dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .we_i(we_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .wdone_o(wdone_o), .select_low_n_o(select_low_n_o),
    .select_high_o(select_high_o), .strobe_n_o(strobe_n_o), .out_en_n_o(out_en_n_o),
    .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dq_i(dq_bus));
  asrp_sram_model mem_u (.select_low_n_i(select_low_n_o), .select_high_i(select_high_o),
    .strobe_n_i(strobe_n_o), .out_en_n_i(out_en_n_o), .addr_i(addr_o), .dq_ctl_i(dq_o),
    .dq_ctl_oe_n_i(dq_oe_n_o), .dq_o(dq_bus), .viol_o(viol));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // one access; for reads d is the expected byte
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 1;
    @(negedge mclk_i);
    `CHK("ready", 1'b1, ready_o)
    req_i = 1'b1;
    we_i = w;
    addr_i = a;
    wdata_i = d;
    @(negedge mclk_i);
    req_i = 1'b0;
    `CHK("sel_low_n", 1'b0, select_low_n_o)
    `CHK("sel_high", 1'b1, select_high_o)
    `CHK("addr", a, addr_o)
    `CHK("out_en_n", w, out_en_n_o)
    while (rvalid_o !== 1'b1 && wdone_o !== 1'b1 && n < 12)
    begin
      @(negedge mclk_i);
      n++;
      if (!w) `CHK("rd_strobe_n", 1'b1, strobe_n_o)
      if (w && n == 2) `CHK("dq_float", 1'b1, dq_oe_n_o)
      if (w && n == 3) `CHK("wr_strobe_n", 1'b0, strobe_n_o)
      if (w && n == 3) `CHK("wr_dq", d, dq_o)
    end
    `CHK("latency", (w ? 5 : 4), n)
    `CHK("done_pulse", 1'b1, (w ? wdone_o : rvalid_o))
    `CHK("other_pulse", 1'b0, (w ? rvalid_o : wdone_o))
    if (!w) `CHK("rdata", d, rdata_o)
    `CHK("model_flag", 1'b0, viol)
    // completion pulse stands one cycle, read byte stands on
    @(negedge mclk_i);
    `CHK("pulse_end", 1'b0, (w ? wdone_o : rvalid_o))
    if (!w) `CHK("rdata_hold", d, rdata_o)
  endtask : xfer
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_idle;
    @(negedge mclk_i);
    `CHK("idle_sel_low_n", 1'b1, select_low_n_o)
    `CHK("idle_sel_high", 1'b0, select_high_o)
    `CHK("idle_strobe_n", 1'b1, strobe_n_o)
    `CHK("idle_dq_oe_n", 1'b1, dq_oe_n_o)
    `CHK("idle_ready", 1'b1, ready_o)
  endtask : t_idle
  // edge addresses written back to back, then read back
  task automatic t_edges;
    logic [ADDR_W-1:0] at [3];
    logic [DATA_W-1:0] dt [3];
    at = '{19'h00000, 19'h7FFFF, 19'h2AAAA};
    dt = '{8'h5A, 8'hA5, 8'h3C};
    for (int i = 0; i < 3; i++) xfer(1'b1, at[i], dt[i]);
    for (int i = 0; i < 3; i++) xfer(1'b0, at[i], dt[i]);
    $display("test edges done");
  endtask : t_edges
  // a write request during a busy read must be dropped
  task automatic t_refuse;
    xfer(1'b1, 19'h00100, 8'h11);
    fork
      xfer(1'b0, 19'h00100, 8'h11);
      begin
        repeat (3) @(negedge mclk_i);
        `CHK("busy_ready", 1'b0, ready_o)
        req_i = 1'b1;
        we_i = 1'b1;
        wdata_i = 8'hEE;
        @(negedge mclk_i);
        req_i = 1'b0;
      end
    join
    repeat (6) @(negedge mclk_i);
    xfer(1'b0, 19'h00100, 8'h11);
    $display("test refuse done");
  endtask : t_refuse
  // reset in the middle of a write frees the memory pins at once
  task automatic t_midreset;
    @(negedge mclk_i);
    req_i = 1'b1;
    we_i = 1'b1;
    addr_i = '0;
    wdata_i = 8'h77;
    repeat (2) @(negedge mclk_i);
    req_i = 1'b0;
    sys_rst_i = 1'b1;
    t_idle();
    sys_rst_i = 1'b0;
    xfer(1'b0, 19'h7FFFF, 8'hA5);
    $display("test midreset done");
  endtask : t_midreset
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_idle();
    $display("test idle done");
    t_edges();
    t_refuse();
    t_midreset();
    end_sim();
  end
  initial
  begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule : testbench
